// [rtl/ppe_power_element.sv]
// power threshold protection element with register port and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "ppe_params.svh"
module ppe_power_element #(
  parameter int unsigned CYC_PER_MS = `PPE_MS_NS / `PPE_CLK_NS,
  parameter int unsigned AVG_CYCLES = `PPE_AVG_WIN_MS * (`PPE_MS_NS / `PPE_CLK_NS),
  parameter int unsigned CNT_W = 24
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [31:0] rdata_o,
  input wire logic meas_valid_i,
  output logic meas_ready_o,
  input wire ppe_pkg::ppe_pwr_t meas_p_i,
  input wire ppe_pkg::ppe_pwr_t meas_q_i,
  input wire ppe_pkg::ppe_pwr_t meas_s_i,
  input wire ppe_pkg::ppe_pwr_t meas_p1_i,
  output logic pickup_o,
  output logic trip_o,
  output logic irq_o
);
  import ppe_pkg::*;

  localparam int DW = 56;

  generate
    if (CYC_PER_MS < 1 || AVG_CYCLES < 2 || CNT_W < 2 || CNT_W > 32
        || AVG_CYCLES > 2 ** CNT_W - 1) begin : g_bad_param
      $error("ppe_power_element parameters out of range");
    end
  endgenerate

  typedef struct packed {
    ppe_fsm_t fsm;
    logic start;
    logic [3:0] mode;
    logic en;
    logic refsec;
    logic [15:0] thr;
    logic [15:0] drop;
    logic [15:0] delay;
    logic [15:0] vt_pri;
    logic [15:0] vt_sec;
    logic [23:0] ct_pri;
    logic [23:0] ct_sec;
    logic [40:0] sn;
    ppe_pwr_t smp_p;
    ppe_pwr_t smp_q;
    ppe_pwr_t smp_s;
    ppe_pwr_t smp_p1;
    ppe_pu_t p_pu;
    ppe_pu_t q_pu;
    ppe_pu_t s_pu;
    ppe_pu_t avg_pu;
    logic avg_ok;
    logic avg_due;
    logic signed [47:0] sum;
    logic signed [47:0] sum_hold;
    logic [CNT_W-1:0] nsmp;
    logic [CNT_W-1:0] nsmp_hold;
    logic [CNT_W-1:0] win;
    logic [31:0] ms_pre;
    logic [15:0] dly;
    logic pickup;
    logic trip;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
    logic irq;
    logic [31:0] rdata;
  } ppe_st_t;

  ppe_st_t st;
  ppe_st_t next_st;
  logic div_done;
  logic [DW-1:0] div_quo;
  logic [DW-1:0] div_num;
  logic [DW-1:0] div_den;

  // ==========================================================================
  // helpers
  function automatic logic [39:0] pwr_mag(input ppe_pwr_t x);
    return x[39] ? 40'(-x) : 40'(x);
  endfunction

  // saturating signed per-unit result from an unsigned quotient
  function automatic ppe_pu_t to_pu(input logic neg, input logic [DW-1:0] q);
    logic [14:0] m;
    m = (|q[DW-1:15]) ? 15'h7fff : q[14:0];
    return neg ? -$signed({1'b0, m}) : $signed({1'b0, m});
  endfunction

  // 2'b01 positive range only, 2'b10 negative only, 2'b11 any sign, 2'b00 off
  function automatic logic [1:0] mode_dir(input ppe_mode_t m);
    case (m)
      forward_active_over, forward_active_under, forward_reactive_over,
      forward_reactive_under, avg_posseq_active_over, avg_posseq_active_under: begin
        mode_dir = 2'b01;
      end
      reverse_active_under, reverse_active_over, reverse_reactive_under,
      reverse_reactive_over, avg_posseq_reverse_over, avg_posseq_reverse_under: begin
        mode_dir = 2'b10;
      end
      apparent_over, apparent_under: begin
        mode_dir = 2'b11;
      end
      default: begin
        mode_dir = 2'b00;
      end
    endcase
  endfunction

  function automatic logic mode_over(input ppe_mode_t m);
    case (m)
      forward_active_over, reverse_active_over, forward_reactive_over,
      reverse_reactive_over, apparent_over, avg_posseq_active_over,
      avg_posseq_reverse_over: begin
        mode_over = 1'b1;
      end
      default: begin
        mode_over = 1'b0;
      end
    endcase
  endfunction

  // ==========================================================================
  // divider shared by all scalings, one division at a time
  always_comb begin
    div_den = {15'h0000, st.sn};
    case (st.fsm)
      ppe_div_p: div_num = {4'h0, pwr_mag(st.smp_p), 12'h000};
      ppe_div_q: div_num = {4'h0, pwr_mag(st.smp_q), 12'h000};
      ppe_div_s: div_num = {4'h0, pwr_mag(st.smp_s), 12'h000};
      ppe_div_p1: div_num = {4'h0, pwr_mag(st.smp_p1), 12'h000};
      ppe_div_avg: begin
        div_num = {8'h00, (st.sum_hold[47] ? 48'(-st.sum_hold) : 48'(st.sum_hold))};
        div_den = {(DW - CNT_W)'(0), st.nsmp_hold};
      end
      default: div_num = '0;
    endcase
  end

  ppe_div #(
    .W(DW)
  ) u_div (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(st.start),
    .dividend_i(div_num),
    .divisor_i(div_den),
    .done_o(div_done),
    .quotient_o(div_quo)
  );

  // ==========================================================================
  // next state
  always_comb begin
    logic [56:0] base;
    logic p1_add;
    ppe_pu_t p1_new;
    logic signed [47:0] acc;
    logic [CNT_W-1:0] ncnt;
    logic win_close;
    ppe_mode_t md;
    ppe_pu_t x;
    logic [15:0] mag;
    logic [31:0] tprod;
    logic [19:0] tdrop;
    logic in_range;
    logic ms_tick;
    logic [2:0] ev;
    logic [2:0] w1c;
    base = '0;
    p1_add = 1'b0;
    p1_new = '0;
    acc = '0;
    ncnt = '0;
    win_close = 1'b0;
    md = ppe_mode_t'(st.mode);
    x = '0;
    mag = '0;
    tprod = '0;
    tdrop = '0;
    in_range = 1'b0;
    ms_tick = 1'b0;
    ev = '0;
    w1c = '0;
    next_st = st;
    next_st.start = 1'b0;
    next_st.rdata = '0;

    // base power from the selected transformer side
    if (st.refsec) begin
      base = 57'(st.vt_sec) * 57'(st.ct_sec) * 57'(`PPE_SQRT3_Q16);
    end else begin
      base = 57'(st.vt_pri) * 57'(st.ct_pri) * 57'(`PPE_SQRT3_Q16);
    end
    next_st.sn = base[56:16];

    // measurement scaling sequence; sign is carried from the raw value, except S, which is always positive
    case (st.fsm)
      ppe_idle: begin
        if (meas_valid_i) begin
          next_st.smp_p = meas_p_i;
          next_st.smp_q = meas_q_i;
          next_st.smp_s = meas_s_i;
          next_st.smp_p1 = meas_p1_i;
          next_st.fsm = ppe_div_p;
          next_st.start = 1'b1;
        end
      end
      ppe_div_p: begin
        if (div_done) begin
          next_st.p_pu = to_pu(st.smp_p[39], div_quo);
          next_st.fsm = ppe_div_q;
          next_st.start = 1'b1;
        end
      end
      ppe_div_q: begin
        if (div_done) begin
          next_st.q_pu = to_pu(st.smp_q[39], div_quo);
          next_st.fsm = ppe_div_s;
          next_st.start = 1'b1;
        end
      end
      ppe_div_s: begin
        if (div_done) begin
          next_st.s_pu = to_pu(1'b0, div_quo);
          next_st.fsm = ppe_div_p1;
          next_st.start = 1'b1;
        end
      end
      ppe_div_p1: begin
        if (div_done) begin
          p1_new = to_pu(st.smp_p1[39], div_quo);
          p1_add = 1'b1;
          if (st.avg_due && st.nsmp_hold != '0) begin
            next_st.fsm = ppe_div_avg;
            next_st.start = 1'b1;
          end else begin
            next_st.fsm = ppe_eval;
          end
        end
      end
      ppe_div_avg: begin
        if (div_done) begin
          next_st.avg_pu = to_pu(st.sum_hold[47], div_quo);
          next_st.avg_ok = 1'b1;
          next_st.fsm = ppe_eval;
        end
      end
      ppe_eval: begin
        next_st.fsm = ppe_idle;
      end
      default: begin
        next_st.fsm = ppe_idle;
      end
    endcase

    // window mean of positive-sequence active power over AVG_CYCLES clocks, 200 ms by default
    win_close = st.win == CNT_W'(AVG_CYCLES - 1);
    acc = st.sum + (p1_add ? {{32{p1_new[15]}}, p1_new} : 48'sh0);
    ncnt = st.nsmp + CNT_W'(p1_add);
    if (win_close) begin
      next_st.win = '0;
      next_st.sum_hold = acc;
      next_st.nsmp_hold = ncnt;
      next_st.sum = '0;
      next_st.nsmp = '0;
      next_st.avg_due = 1'b1;
    end else begin
      next_st.win = st.win + 1'b1;
      next_st.sum = acc;
      next_st.nsmp = ncnt;
      if (st.fsm == ppe_div_p1 && div_done) begin
        next_st.avg_due = 1'b0;
      end
    end

    // threshold comparison in per-unit, with hysteresis from the dropout ratio
    case (md)
      forward_active_over, forward_active_under, reverse_active_under,
      reverse_active_over: x = st.p_pu;
      forward_reactive_over, forward_reactive_under, reverse_reactive_under,
      reverse_reactive_over: x = st.q_pu;
      apparent_over, apparent_under: x = st.s_pu;
      default: x = st.avg_pu;
    endcase
    mag = x[15] ? 16'(-x) : 16'(x);
    tprod = 32'(st.thr) * 32'(st.drop);
    tdrop = tprod[31:12];
    case (mode_dir(md))
      2'b01: in_range = (x > 16'sh0);
      2'b10: in_range = (x < 16'sh0);
      2'b11: in_range = 1'b1;
      default: in_range = 1'b0;
    endcase
    if (md >= avg_posseq_active_over && !st.avg_ok) begin
      in_range = 1'b0;
    end
    if (!st.en) begin
      next_st.pickup = 1'b0;
    end else if (st.fsm == ppe_eval) begin
      if (mode_over(md)) begin
        next_st.pickup = in_range && (st.pickup ? ({4'h0, mag} > tdrop) : (mag > st.thr));
      end else begin
        next_st.pickup = in_range && (st.pickup ? ({4'h0, mag} < tdrop) : (mag < st.thr));
      end
    end

    // millisecond delay timer, restarted on each fresh pickup
    ms_tick = st.ms_pre == CYC_PER_MS - 1;
    if (!st.pickup) begin
      next_st.ms_pre = '0;
      next_st.dly = '0;
    end else begin
      next_st.ms_pre = ms_tick ? '0 : st.ms_pre + 1'b1;
      if (ms_tick && st.dly != 16'hffff) begin
        next_st.dly = st.dly + 1'b1;
      end
    end
    next_st.trip = st.pickup && next_st.pickup && (st.dly >= st.delay);

    // register writes
    if (we_i) begin
      case (addr_i)
        `PPE_OFS_CTRL: begin
          next_st.mode = wdata_i[`PPE_CTRL_MODE_MSB:`PPE_CTRL_MODE_LSB];
          next_st.en = wdata_i[`PPE_CTRL_ENABLE_BIT];
          next_st.refsec = wdata_i[`PPE_CTRL_REFSEC_BIT];
        end
        `PPE_OFS_THRESHOLD: next_st.thr = wdata_i[15:0];
        `PPE_OFS_DROPOUT: next_st.drop = wdata_i[15:0];
        `PPE_OFS_DELAY: next_st.delay = wdata_i[15:0];
        `PPE_OFS_VT_PRI: next_st.vt_pri = wdata_i[15:0];
        `PPE_OFS_CT_PRI: next_st.ct_pri = wdata_i[23:0];
        `PPE_OFS_VT_SEC: next_st.vt_sec = wdata_i[15:0];
        `PPE_OFS_CT_SEC: next_st.ct_sec = wdata_i[23:0];
        `PPE_OFS_IRQ_STATUS: w1c = wdata_i[2:0];
        `PPE_OFS_IRQ_MASK: next_st.irq_mask = wdata_i[2:0];
        default: begin
        end
      endcase
    end

    // sticky events; a new event beats a simultaneous clear
    ev[`PPE_IRQ_PICKUP_BIT] = next_st.pickup && !st.pickup;
    ev[`PPE_IRQ_TRIP_BIT] = next_st.trip && !st.trip;
    ev[`PPE_IRQ_DROP_BIT] = !next_st.pickup && st.pickup;
    next_st.irq_st = (st.irq_st & ~w1c) | ev;
    next_st.irq = |(next_st.irq_st & next_st.irq_mask);

    // register reads, data valid in the following cycle only
    if (re_i) begin
      case (addr_i)
        `PPE_OFS_CTRL: next_st.rdata = {26'h0, st.refsec, st.en, st.mode};
        `PPE_OFS_THRESHOLD: next_st.rdata = {16'h0, st.thr};
        `PPE_OFS_DROPOUT: next_st.rdata = {16'h0, st.drop};
        `PPE_OFS_DELAY: next_st.rdata = {16'h0, st.delay};
        `PPE_OFS_VT_PRI: next_st.rdata = {16'h0, st.vt_pri};
        `PPE_OFS_CT_PRI: next_st.rdata = {8'h0, st.ct_pri};
        `PPE_OFS_VT_SEC: next_st.rdata = {16'h0, st.vt_sec};
        `PPE_OFS_CT_SEC: next_st.rdata = {8'h0, st.ct_sec};
        `PPE_OFS_STATUS: next_st.rdata = {30'h0, st.trip, st.pickup};
        `PPE_OFS_MEAS_P: next_st.rdata = {{16{st.p_pu[15]}}, st.p_pu};
        `PPE_OFS_MEAS_Q: next_st.rdata = {{16{st.q_pu[15]}}, st.q_pu};
        `PPE_OFS_MEAS_S: next_st.rdata = {{16{st.s_pu[15]}}, st.s_pu};
        `PPE_OFS_MEAS_AVG: next_st.rdata = {{16{st.avg_pu[15]}}, st.avg_pu};
        `PPE_OFS_IRQ_STATUS: next_st.rdata = {29'h0, st.irq_st};
        `PPE_OFS_IRQ_MASK: next_st.rdata = {29'h0, st.irq_mask};
        default: next_st.rdata = '0;
      endcase
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
      st.fsm <= ppe_idle;
      st.thr <= `PPE_RST_THRESHOLD;
      st.drop <= `PPE_RST_DROPOUT;
      st.delay <= `PPE_RST_DELAY;
      st.vt_pri <= `PPE_RST_VT;
      st.vt_sec <= `PPE_RST_VT;
      st.ct_pri <= `PPE_RST_CT;
      st.ct_sec <= `PPE_RST_CT;
      st.irq_mask <= `PPE_RST_IRQ_MASK;
    end else begin
      st <= next_st;
    end
  end

  assign meas_ready_o = (st.fsm == ppe_idle);
  assign rdata_o = st.rdata;
  assign pickup_o = st.pickup;
  assign trip_o = st.trip;
  assign irq_o = st.irq;
endmodule // ppe_power_element
`default_nettype wire

// [include/ppe_params.svh]
// register offsets, field positions, reset values and timing counts of the power element
`ifndef PPE_PARAMS_SVH
`define PPE_PARAMS_SVH
// ==========================================================================
// register byte offsets
`define PPE_OFS_CTRL 8'h00
`define PPE_OFS_THRESHOLD 8'h04
`define PPE_OFS_DROPOUT 8'h08
`define PPE_OFS_DELAY 8'h0c
`define PPE_OFS_VT_PRI 8'h10
`define PPE_OFS_CT_PRI 8'h14
`define PPE_OFS_VT_SEC 8'h18
`define PPE_OFS_CT_SEC 8'h1c
`define PPE_OFS_STATUS 8'h20
`define PPE_OFS_MEAS_P 8'h24
`define PPE_OFS_MEAS_Q 8'h28
`define PPE_OFS_MEAS_S 8'h2c
`define PPE_OFS_MEAS_AVG 8'h30
`define PPE_OFS_IRQ_STATUS 8'h34
`define PPE_OFS_IRQ_MASK 8'h38
// ==========================================================================
// field positions
`define PPE_CTRL_MODE_LSB 0
`define PPE_CTRL_MODE_MSB 3
`define PPE_CTRL_ENABLE_BIT 4
`define PPE_CTRL_REFSEC_BIT 5
`define PPE_STAT_PICKUP_BIT 0
`define PPE_STAT_TRIP_BIT 1
`define PPE_IRQ_PICKUP_BIT 0
`define PPE_IRQ_TRIP_BIT 1
`define PPE_IRQ_DROP_BIT 2
// ==========================================================================
// reset values
`define PPE_RST_CTRL 6'h00
`define PPE_RST_THRESHOLD 16'h1000
`define PPE_RST_DROPOUT 16'h1000
`define PPE_RST_DELAY 16'h0000
`define PPE_RST_VT 16'h0000
`define PPE_RST_CT 24'h000000
`define PPE_RST_IRQ_MASK 3'h0
// ==========================================================================
// arithmetic and timing
`define PPE_PU_FRAC 12
`define PPE_SQRT3_Q16 17'h1bb68
`define PPE_CLK_NS 20
`define PPE_MS_NS 1000000
`define PPE_AVG_WIN_MS 200
`endif

// [include/ppe_pkg.sv]
// types shared by the power threshold protection element
`default_nettype none
package ppe_pkg;
  typedef enum logic [3:0] {
    forward_active_over, forward_active_under, reverse_active_under, reverse_active_over,
    forward_reactive_over, forward_reactive_under, reverse_reactive_under,
    reverse_reactive_over, apparent_over, apparent_under, avg_posseq_active_over,
    avg_posseq_active_under, avg_posseq_reverse_over, avg_posseq_reverse_under
  } ppe_mode_t;
  typedef enum logic [2:0] {
    ppe_idle, ppe_div_p, ppe_div_q, ppe_div_s, ppe_div_p1, ppe_div_avg, ppe_eval
  } ppe_fsm_t;
  typedef logic signed [39:0] ppe_pwr_t;
  typedef logic signed [15:0] ppe_pu_t;
endpackage
`default_nettype wire

// [rtl/ppe_div.sv]
// sequential restoring divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
module ppe_div #(
  parameter int W = 56
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic [W-1:0] dividend_i,
  input wire logic [W-1:0] divisor_i,
  output logic done_o,
  output logic [W-1:0] quotient_o
);
  import ppe_pkg::*;

  typedef struct packed {
    logic busy;
    logic done;
    logic [$clog2(W+1)-1:0] cnt;
    logic [W-1:0] rem;
    logic [W-1:0] quo;
    logic [W-1:0] dsr;
  } ppe_div_st_t;

  ppe_div_st_t st;
  ppe_div_st_t next_st;

  generate
    if (W < 2) begin : g_bad_width
      $error("ppe_div needs at least two bits");
    end
  endgenerate

  // ==========================================================================
  // datapath
  always_comb begin
    logic [W:0] trial;
    trial = {st.rem, st.quo[W-1]};
    next_st = st;
    next_st.done = 1'b0;
    if (start_i) begin
      next_st.busy = 1'b1;
      next_st.cnt = ($clog2(W+1))'(W);
      next_st.rem = '0;
      next_st.quo = dividend_i;
      next_st.dsr = divisor_i;
    end else if (st.busy) begin
      // zero divisor yields all ones, which the caller saturates
      if (trial >= {1'b0, st.dsr}) begin
        next_st.rem = W'(trial - {1'b0, st.dsr});
        next_st.quo = {st.quo[W-2:0], 1'b1};
      end else begin
        next_st.rem = trial[W-1:0];
        next_st.quo = {st.quo[W-2:0], 1'b0};
      end
      next_st.cnt = st.cnt - 1'b1;
      if (st.cnt == ($clog2(W+1))'(1)) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done_o = st.done;
  assign quotient_o = st.quo;
endmodule // ppe_div
`default_nettype wire

// [verif/ppe_power_element_assertions.sv]
// port checker for the power element, bound to the top module
`timescale 1ns/1ps
`default_nettype none
`include "ppe_params.svh"
// ==========
// checker
module ppe_power_element_assertions #(
  parameter int unsigned CYC_PER_MS = 4
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [31:0] rdata_o,
  input wire logic meas_valid_i,
  input wire logic meas_ready_o,
  input wire logic pickup_o,
  input wire logic trip_o,
  input wire logic irq_o
);
  logic [15:0] dly;
  logic [2:0] msk;
  logic [23:0] pk_cnt;
  logic [9:0] busy_cnt;
  logic [23:0] d_need;
  // shadows of the delay and mask writes, so timing can be judged from the ports
  assign d_need = 24'(dly) * 24'(CYC_PER_MS) + 24'h1;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dly <= 16'h0;
      msk <= 3'h0;
      pk_cnt <= 24'h0;
      busy_cnt <= 10'h0;
    end else begin
      if (we_i && addr_i == `PPE_OFS_DELAY) dly <= wdata_i[15:0];
      if (we_i && addr_i == `PPE_OFS_IRQ_MASK) msk <= wdata_i[2:0];
      pk_cnt <= pickup_o ? pk_cnt + 24'h1 : 24'h0;
      busy_cnt <= (meas_valid_i && meas_ready_o) ? 10'h1 :
                  (meas_ready_o ? busy_cnt : busy_cnt + 10'h1);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_taken;
    meas_valid_i && meas_ready_o;
  endsequence
  sequence s_busy;
    !meas_ready_o [*8];
  endsequence
  AST_RDATA_IDLE: assert property (!re_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  AST_UNMAPPED_READ: assert property (re_i && addr_i > `PPE_OFS_IRQ_MASK |=> rdata_o == 32'h0)
    else $error("unmapped read returned data");
  AST_TAKE_BUSY: assert property (s_taken |=> s_busy)
    else $error("ready came back too soon after a sample");
  AST_ANSWER_TIME: assert property ($rose(meas_ready_o) |->
    busy_cnt inside {[10'd232:10'd236], [10'd290:10'd294]})
    else $error("sample answer time off");
  AST_PICKUP_AT_EVAL: assert property ($changed(pickup_o) |-> !$past(meas_ready_o))
    else $error("pickup moved outside an evaluation");
  AST_TRIP_WITH_PICKUP: assert property (trip_o |-> pickup_o)
    else $error("trip without pickup");
  AST_TRIP_DELAY: assert property ($rose(trip_o) |-> pk_cnt >= d_need && pk_cnt <= d_need + 24'h1)
    else $error("trip delay off");
  AST_IRQ_MASKED: assert property (msk == 3'h0 |-> !irq_o)
    else $error("interrupt with all sources masked");
  AST_PICKUP_IRQ: assert property ($rose(pickup_o) && msk[0] |-> ##[0:2] irq_o)
    else $error("pickup event raised no interrupt");
endmodule // ppe_power_element_assertions
bind ppe_power_element ppe_power_element_assertions #(.CYC_PER_MS(CYC_PER_MS)) u_ast (
  .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
  .re_i(re_i), .rdata_o(rdata_o), .meas_valid_i(meas_valid_i), .meas_ready_o(meas_ready_o),
  .pickup_o(pickup_o), .trip_o(trip_o), .irq_o(irq_o));
`default_nettype wire

// [verif/ppe_meas_src.sv]
// measurement front end model that offers power samples
`timescale 1ns/1ps
`default_nettype none
// ==========
// sample source
module ppe_meas_src (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire logic [3:0] lag_i,
  input wire ppe_pkg::ppe_pwr_t p_i,
  input wire ppe_pkg::ppe_pwr_t q_i,
  input wire ppe_pkg::ppe_pwr_t s_i,
  input wire ppe_pkg::ppe_pwr_t p1_i,
  input wire logic meas_ready_i,
  output logic meas_valid_o,
  output ppe_pkg::ppe_pwr_t meas_p_o,
  output ppe_pkg::ppe_pwr_t meas_q_o,
  output ppe_pkg::ppe_pwr_t meas_s_o,
  output ppe_pkg::ppe_pwr_t meas_p1_o
);
  import ppe_pkg::*;
  ppe_pwr_t sp, sq, ss, sp1;
  logic pend;
  logic [3:0] cnt;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meas_valid_o <= 1'b0;
      pend <= 1'b0;
      cnt <= 4'h0;
      meas_p_o <= '1;
      meas_q_o <= '1;
      meas_s_o <= '1;
      meas_p1_o <= '1;
    end else if (req_i) begin
      pend <= 1'b1;
      cnt <= lag_i;
      sp <= p_i;
      sq <= q_i;
      ss <= s_i;
      sp1 <= p1_i;
    end else if (pend && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (pend && !meas_valid_o) begin
      meas_valid_o <= 1'b1;
      meas_p_o <= sp;
      meas_q_o <= sq;
      meas_s_o <= ss;
      meas_p1_o <= sp1;
    end else if (meas_valid_o && meas_ready_i) begin
      // released lines show the inverse so a stale capture cannot pass
      meas_valid_o <= 1'b0;
      pend <= 1'b0;
      meas_p_o <= ~sp;
      meas_q_o <= ~sq;
      meas_s_o <= ~ss;
      meas_p1_o <= ~sp1;
    end
  end
endmodule // ppe_meas_src
`default_nettype wire

// [verif/power_threshold_protection_tb.sv]
// self-checking bench for the power threshold element
`timescale 1ns/1ps
`default_nettype none
`include "ppe_params.svh"
// ==========
// bench
module power_threshold_protection_tb;
  import ppe_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, we = 1'b0, re = 1'b0, req = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] lag = 4'h0;
  logic mv, mr, pickup, trip, irq;
  ppe_pwr_t tp = '0, tq = '0, ts = '0, tp1 = '0, mp, mq, ms, mp1;
  int n_mismatch = 0;
  int n_tests = 0;
  longint bs, bp;
  // table of mode rows: sample in quarters of base, 2 sits on the threshold
  int rm[19] = '{0, 0, 1, 1, 2, 3, 3, 4, 4, 5, 6, 7, 7, 8, 9, 14, 11, 12, 13};
  int rp[19] = '{4, -4, 1, -1, -1, -4, 4, 2, 2, 2, 2, 2, 2, -4, 2, 4, 0, 0, 0};
  int rq[19] = '{2, 2, 2, 2, 2, 2, 2, 4, -4, 1, -1, -4, 4, -4, 2, 4, 0, 0, 0};
  int rs[19] = '{2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 4, 1, 4, 0, 0, 0};
  logic re_x[19] = '{1, 0, 1, 0, 1, 1, 0, 1, 0, 1, 1, 1, 0, 1, 1, 0, 0, 0, 0};
  always #10 clk = ~clk;
  ppe_power_element #(.CYC_PER_MS(4), .AVG_CYCLES(2000), .CNT_W(24)) dut (
    .clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re),
    .rdata_o(rdata), .meas_valid_i(mv), .meas_ready_o(mr), .meas_p_i(mp), .meas_q_i(mq),
    .meas_s_i(ms), .meas_p1_i(mp1), .pickup_o(pickup), .trip_o(trip), .irq_o(irq));
  ppe_meas_src u_src (
    .clk_i(clk), .nrst_i(nrst), .req_i(req), .lag_i(lag), .p_i(tp), .q_i(tq), .s_i(ts),
    .p1_i(tp1), .meas_ready_i(mr), .meas_valid_o(mv), .meas_p_o(mp), .meas_q_o(mq),
    .meas_s_o(ms), .meas_p1_o(mp1));
  // ==========
  // tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 chk(nm, exp, rdata);
  endtask
  // lg stretches the source's reply so slow offers are exercised too
  task automatic send(input longint p, q, s, p1, input logic [3:0] lg);
    int k;
    @(posedge clk);
    tp <= p[39:0];
    tq <= q[39:0];
    ts <= s[39:0];
    tp1 <= p1[39:0];
    lag <= lg;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    k = 0;
    while (mr !== 1'b0 && k < 60) begin
      @(posedge clk);
      k++;
    end
    chk("meas taken", 32'h0, {31'h0, mr});
    while (mr !== 1'b1 && k < 500) begin
      @(posedge clk);
      k++;
    end
    #1 chk("meas_ready", 32'h1, {31'h0, mr});
  endtask
  function automatic logic [31:0] pu(input longint x, input longint b);
    longint r;
    r = (x * 4096) / b;
    return r[31:0];
  endfunction
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========
  // watchdog, more than four times the expected run
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    $display("watchdog expired");
    wrap_up();
  end
  // ==========
  // tests
  initial begin
    bs = (64'd100 * 64'd5000 * `PPE_SQRT3_Q16) >> 16;
    bp = (64'd200 * 64'd5000 * `PPE_SQRT3_Q16) >> 16;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd(`PPE_OFS_CTRL, 32'(`PPE_RST_CTRL), "ctrl");
    rd(`PPE_OFS_THRESHOLD, 32'(`PPE_RST_THRESHOLD), "threshold");
    rd(`PPE_OFS_DROPOUT, 32'(`PPE_RST_DROPOUT), "dropout");
    rd(`PPE_OFS_DELAY, 32'(`PPE_RST_DELAY), "delay");
    rd(`PPE_OFS_IRQ_MASK, 32'(`PPE_RST_IRQ_MASK), "irq_mask");
    wr(`PPE_OFS_STATUS, 32'h3);
    rd(`PPE_OFS_STATUS, 32'h0, "status read only");
    rd(8'h3c, 32'h0, "unmapped");
    done("reset values");
    wr(`PPE_OFS_VT_PRI, 32'd200);
    wr(`PPE_OFS_CT_PRI, 32'd5000);
    wr(`PPE_OFS_VT_SEC, 32'd100);
    wr(`PPE_OFS_CT_SEC, 32'd5000);
    wr(`PPE_OFS_THRESHOLD, 32'h800);
    wr(`PPE_OFS_CTRL, 32'h3a);
    send(bs, bs, bs, bs, 4'h0);
    chk("pickup before window", 32'h0, {31'h0, pickup});
    repeat (19) send(bs, bs, bs, bs, 4'h2);
    chk("pickup averaged", 32'h1, {31'h0, pickup});
    rd(`PPE_OFS_MEAS_AVG, 32'h1000, "avg");
    done("averaged mode");
    send(bs * 866 / 1000, bs / 2, bs, bs, 4'h0);
    rd(`PPE_OFS_MEAS_P, pu(bs * 866 / 1000, bs), "meas_p");
    rd(`PPE_OFS_MEAS_Q, pu(bs / 2, bs), "meas_q");
    rd(`PPE_OFS_MEAS_S, 32'h1000, "meas_s");
    wr(`PPE_OFS_CTRL, 32'h1a);
    send(0, bs, bs, bs, 4'h0);
    rd(`PPE_OFS_MEAS_Q, pu(bs, bp), "meas_q primary");
    rd(`PPE_OFS_MEAS_P, 32'h0, "meas_p primary");
    done("scaling");
    for (int i = 0; i < 19; i++) begin
      wr(`PPE_OFS_CTRL, 32'h30 | 32'(rm[i]));
      send(rp[i] * bs / 4, rq[i] * bs / 4, rs[i] * bs / 4, bs, 4'(3 * (i % 2)));
      chk("mode pickup", {31'h0, re_x[i]}, {31'h0, pickup});
    end
    done("modes");
    wr(`PPE_OFS_DROPOUT, 32'hc00);
    wr(`PPE_OFS_DELAY, 32'd2);
    wr(`PPE_OFS_CTRL, 32'h30);
    send(bs / 4, 0, 0, bs, 4'h0);
    wr(`PPE_OFS_IRQ_STATUS, 32'h7);
    rd(`PPE_OFS_IRQ_STATUS, 32'h0, "irq clear");
    send(bs, 0, 0, bs, 4'h1);
    chk("trip early", 32'h0, {31'h0, trip});
    repeat (12) @(posedge clk);
    #1 chk("trip", 32'h1, {31'h0, trip});
    rd(`PPE_OFS_IRQ_STATUS, 32'h3, "irq events");
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`PPE_OFS_IRQ_MASK, 32'h7);
    @(posedge clk);
    #1 chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(`PPE_OFS_IRQ_STATUS, 32'h3);
    rd(`PPE_OFS_IRQ_STATUS, 32'h0, "irq cleared");
    chk("irq low", 32'h0, {31'h0, irq});
    send(bs * 45 / 100, 0, 0, bs, 4'h0);
    chk("pickup held", 32'h1, {31'h0, pickup});
    send(bs / 4, 0, 0, bs, 4'h0);
    chk("pickup drop", 32'h0, {31'h0, pickup});
    chk("trip drop", 32'h0, {31'h0, trip});
    rd(`PPE_OFS_IRQ_STATUS, 32'h4, "irq drop");
    chk("irq drop", 32'h1, {31'h0, irq});
    wr(`PPE_OFS_IRQ_MASK, 32'h3);
    @(posedge clk);
    #1 chk("irq remasked", 32'h0, {31'h0, irq});
    done("trip and interrupts");
    wr(`PPE_OFS_DELAY, 32'd100);
    send(bs, 0, 0, bs, 4'h0);
    send(bs / 4, 0, 0, bs, 4'h0);
    send(bs, 0, 0, bs, 4'h0);
    repeat (300) @(posedge clk);
    #1 chk("trip restarted", 32'h0, {31'h0, trip});
    repeat (120) @(posedge clk);
    #1 chk("trip after delay", 32'h1, {31'h0, trip});
    done("timer restart");
    wrap_up();
  end
endmodule // power_threshold_protection_tb
`default_nettype wire
